// ===== verilog/tosc_top.sv
// Timer output gating, pin direction, ch0 interrupt flag/mask and start trigger logic
// What this block does
// - Output enable 0: software writes ch0 output value, pin shows that bit.
// - Output enable 1: software writes to ch0 output value ignored; timer drives it.
// - Output enable 1: ch0 pin carries the timer square wave; only the ch1 pin carries a PWM waveform, in slave mode.
// - Direction bit 4 at 0 enables pin buffer; at 1 pin is input, buffer off.
// - ch0 interrupt flag in bit 7 reads 1 while a request pends, else 0.
// - ch0 mask bit 7 at 0 allows servicing, at 1 blocks it.
// - Writing 1 to a start bit sets that channel's enable status; 0 does nothing.
// - Actual counting start after enable follows the channel's operating mode.
// - Slave mode: ch1 output set by master count end, reset by slave count end.
// - Duty equals slave compare over master period plus one.
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

module tosc_top
  import tosc_pkg::*;
(
  input  wire logic        mclk_i,              // 250 MHz clock
  input  wire logic        rst_i,               // Synchronous reset, high
  input  wire logic        ce_i,                // Clock enable, freezes state when low
  input  wire logic [5:0]  avs_address_i,       // Byte address
  input  wire logic        avs_read_i,          // Read request
  input  wire logic        avs_write_i,         // Write request
  input  wire logic [3:0]  avs_byteenable_i,    // Byte lanes
  input  wire logic [31:0] avs_writedata_i,     // Write data
  output logic      [31:0] avs_readdata_o,      // Read data
  output logic             avs_waitrequest_o,   // Low when access completes
  input  wire logic        ch0_count_end_irq_i, // Pulse: ch0 period end (master)
  input  wire logic        ch1_count_end_irq_i, // Pulse: ch1 compare match (slave)
  output logic      [1:0]  ch_start_o,          // Pulse: start trigger to counters
  output logic      [1:0]  ch_enable_status_o,  // Enable status per channel
  output logic             ch0_pin_o,           // ch0 pin output level
  output logic             ch0_pin_oe_o,        // ch0 pin buffer enable
  output logic             ch1_pin_o,           // ch1 pin output level
  output logic             ch1_pin_oe_o,        // ch1 pin buffer enable
  output logic             irq_o                // Level interrupt
);

  // ==========================================================================
  // State
  // ==========================================================================
  tosc_state_t   st_r;
  tosc_state_t   st_nxt;
  tosc_bus_req_t req;
  logic [1:0]    start_nxt;
  logic [1:0]    start_r;
  logic [1:0]    ch0_sync_r;  // Sync pair for ch0 event from counter domain boundary
  logic [1:0]    ch1_sync_r;
  logic          ch0_evt_q_r;
  logic          ch1_evt_q_r;
  logic          ch0_evt;
  logic          ch1_evt;
  logic [1:0]    page;
  logic [3:0]    ofs;
  logic [7:0]    wbyte;
  logic          wr_hit;
  logic          rd_hit;

  assign req = '{read: avs_read_i, write: avs_write_i, address: avs_address_i,
                 byteenable: avs_byteenable_i, writedata: avs_writedata_i};
  assign page  = req.address[5:4];
  assign ofs   = req.address[3:0];
  assign wbyte = req.writedata[7:0];
  // Only the low lane carries register data; other lanes are ignored
  assign wr_hit = req.write && req.byteenable[0] && !st_r.ack;
  assign rd_hit = req.read && !st_r.ack;

  // ==========================================================================
  // Event synchronisers and edge detect
  // ==========================================================================
  // Count-end signals come from the counter array pins; treat as asynchronous
  // levels and detect rising edges only after two flops.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ch0_sync_r  <= 2'h0;
      ch1_sync_r  <= 2'h0;
      ch0_evt_q_r <= 1'b0;
      ch1_evt_q_r <= 1'b0;
    end else if (ce_i) begin
      ch0_sync_r  <= {ch0_sync_r[0], ch0_count_end_irq_i};
      ch1_sync_r  <= {ch1_sync_r[0], ch1_count_end_irq_i};
      ch0_evt_q_r <= ch0_sync_r[1];
      ch1_evt_q_r <= ch1_sync_r[1];
    end
  end

  assign ch0_evt = ch0_sync_r[1] && !ch0_evt_q_r;
  assign ch1_evt = ch1_sync_r[1] && !ch1_evt_q_r;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    st_nxt    = st_r;
    start_nxt = 2'h0;
    st_nxt.ack   = 1'b0;
    st_nxt.rdata = st_r.rdata;

    // Bus writes: one-cycle wait then acknowledge
    if (wr_hit) begin
      st_nxt.ack = 1'b1;
      if (page == TOSC_PAGE_A) begin
        case (ofs)
          TOSC_OFS_PORT0_LATCH: st_nxt.port0_latch = wbyte;
          TOSC_OFS_PORT0_DIR:   st_nxt.port0_dir   = wbyte;
          TOSC_OFS_IRQ_FLAGS: st_nxt.irq_flags = wbyte;
          TOSC_OFS_IRQ_MASK:  st_nxt.irq_mask  = wbyte;
          default: ;
        endcase
      end else if (page == TOSC_PAGE_B) begin
        case (ofs)
          TOSC_OFS_START: begin
            // Only ones act; zeros leave enable status alone
            st_nxt.en_status = st_r.en_status | wbyte[1:0];
            start_nxt        = wbyte[1:0];
          end
          TOSC_OFS_OUT_CTL: st_nxt.out_en = wbyte[1:0];
          TOSC_OFS_OUT_VAL: begin
            // Each channel's value bit is writable only with its output disabled
            for (int i = 0; i < 2; i++) begin
              if (!st_r.out_en[i]) begin
                st_nxt.out_val[i] = wbyte[i];
              end
            end
          end
          default: ;
        endcase
      end else if (page == TOSC_PAGE_C && ofs == TOSC_OFS_MODE) begin
        st_nxt.ch1_slave = wbyte[TOSC_CH0_BIT];
      end
    end else if (rd_hit) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = TOSC_UNMAPPED;
      if (page == TOSC_PAGE_A) begin
        case (ofs)
          TOSC_OFS_PORT0_LATCH: st_nxt.rdata[7:0] = st_r.port0_latch;
          TOSC_OFS_PORT0_DIR:   st_nxt.rdata[7:0] = st_r.port0_dir;
          TOSC_OFS_IRQ_FLAGS: begin
            st_nxt.rdata[7:0] = st_r.irq_flags;
            st_nxt.irq_flags  = TOSC_FLAG_RST;                // Read clears sticky bits
          end
          TOSC_OFS_IRQ_MASK:  st_nxt.rdata[7:0] = st_r.irq_mask;
          default: ;
        endcase
      end else if (page == TOSC_PAGE_B) begin
        case (ofs)
          TOSC_OFS_OUT_CTL: st_nxt.rdata[1:0] = st_r.out_en;
          TOSC_OFS_OUT_VAL: st_nxt.rdata[1:0] = st_r.out_val;
          TOSC_OFS_STATUS:  st_nxt.rdata[1:0] = st_r.en_status;
          default: ;
        endcase
      end else if (page == TOSC_PAGE_C && ofs == TOSC_OFS_MODE) begin
        st_nxt.rdata[0] = st_r.ch1_slave;
      end
    end

    // Hardware set wins over a software clear in the same cycle
    if (ch0_evt) begin
      st_nxt.irq_flags[TOSC_CH0_IRQ_BIT] = 1'b1;
    end

    // Timer drives the output value while the output is enabled
    if (st_r.out_en[TOSC_CH0_BIT] && st_r.en_status[TOSC_CH0_BIT] && ch0_evt) begin
      st_nxt.out_val[TOSC_CH0_BIT] = !st_r.out_val[TOSC_CH0_BIT];
    end
    if (st_r.out_en[TOSC_CH1_BIT] && st_r.en_status[TOSC_CH1_BIT]) begin
      if (st_r.ch1_slave) begin
        // Reset after set: a coincident compare of zero gives 0% duty
        if (ch0_evt) begin
          st_nxt.out_val[TOSC_CH1_BIT] = 1'b1;
        end
        if (ch1_evt) begin
          st_nxt.out_val[TOSC_CH1_BIT] = 1'b0;
        end
      end else if (ch1_evt) begin
        st_nxt.out_val[TOSC_CH1_BIT] = !st_r.out_val[TOSC_CH1_BIT];
      end
    end

    // Pin drivers registered from the value and direction bits
    st_nxt.pin0.pin_o  = st_nxt.out_val[TOSC_CH0_BIT];
    st_nxt.pin0.pin_oe = !st_nxt.port0_dir[TOSC_PIN4_BIT];
    st_nxt.pin1.pin_o  = st_nxt.out_val[TOSC_CH1_BIT];
    st_nxt.pin1.pin_oe = !st_nxt.port0_dir[TOSC_PIN4_BIT + 1];
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r           <= '0;
      st_r.port0_latch <= TOSC_PORT0_RST;
      st_r.port0_dir   <= TOSC_DIR_RST;
      st_r.irq_flags <= TOSC_FLAG_RST;
      st_r.irq_mask  <= TOSC_MASK_RST;
      start_r        <= 2'h0;
    end else if (ce_i) begin
      st_r    <= st_nxt;
      start_r <= start_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign avs_readdata_o     = st_r.rdata;
  assign avs_waitrequest_o  = !st_r.ack;
  assign ch_start_o         = start_r;
  assign ch_enable_status_o = st_r.en_status;
  assign ch0_pin_o          = st_r.pin0.pin_o;
  assign ch0_pin_oe_o       = st_r.pin0.pin_oe;
  assign ch1_pin_o          = st_r.pin1.pin_o;
  assign ch1_pin_oe_o       = st_r.pin1.pin_oe;
  // Mask bit 0 lets the pending flag through
  assign irq_o = |(st_r.irq_flags & ~st_r.irq_mask);

endmodule : tosc_top

// ===== verilog/tosc_pkg.sv
// Package of register map, field positions and types for the timer output and start control block
package tosc_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the Avalon-MM slave)
  // ==========================================================================
  localparam logic [3:0] TOSC_OFS_PORT0_LATCH = 4'h0; // port0_output_latch
  localparam logic [3:0] TOSC_OFS_PORT0_DIR   = 4'h4; // port0_direction
  localparam logic [3:0] TOSC_OFS_IRQ_FLAGS = 4'h8; // interrupt_request_flags_low
  localparam logic [3:0] TOSC_OFS_IRQ_MASK  = 4'hC; // interrupt_mask_flags_low
  // Second page of the map
  localparam logic [3:0] TOSC_OFS_START     = 4'h0; // channel_start_trigger, write only
  localparam logic [3:0] TOSC_OFS_OUT_CTL   = 4'h4; // Output enable bits
  localparam logic [3:0] TOSC_OFS_OUT_VAL   = 4'h8; // Output value bits
  localparam logic [3:0] TOSC_OFS_STATUS    = 4'hC; // Enable status, read only
  localparam logic [3:0] TOSC_OFS_MODE      = 4'h0; // Channel 1 output mode (third page)
  localparam logic [1:0] TOSC_PAGE_A        = 2'h0;
  localparam logic [1:0] TOSC_PAGE_B        = 2'h1;
  localparam logic [1:0] TOSC_PAGE_C        = 2'h2;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned TOSC_PIN4_BIT     = 4;  // pin4 in port 0 registers
  localparam int unsigned TOSC_CH0_IRQ_BIT  = 7;  // ch0 flag and mask bit
  localparam int unsigned TOSC_CH0_BIT      = 0;  // Channel 0 in per-channel registers
  localparam int unsigned TOSC_CH1_BIT      = 1;  // Channel 1 in per-channel registers
  localparam logic [7:0]  TOSC_PORT0_RST    = 8'h00;
  localparam logic [7:0]  TOSC_DIR_RST      = 8'hFF; // All pins input after reset
  localparam logic [7:0]  TOSC_FLAG_RST     = 8'h00;
  localparam logic [7:0]  TOSC_MASK_RST     = 8'hFF; // All sources masked after reset
  localparam logic [31:0] TOSC_UNMAPPED     = 32'h0000_0000;

  // Bus access types
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } tosc_bus_req_t;

  typedef struct packed {
    logic        pin_o;
    logic        pin_oe;
  } tosc_pin_t;

  // Whole block state
  typedef struct packed {
    logic [7:0]  port0_latch;
    logic [7:0]  port0_dir;
    logic [7:0]  irq_flags;
    logic [7:0]  irq_mask;
    logic [1:0]  out_en;
    logic [1:0]  out_val;
    logic [1:0]  en_status;
    logic        ch1_slave;
    logic        ack;
    logic [31:0] rdata;
    tosc_pin_t   pin0;
    tosc_pin_t   pin1;
  } tosc_state_t;

endpackage : tosc_pkg

// ===== tb/tosc_properties.sv
// Port checks for the timer output and start control block
`timescale 1ns/1ps
module tosc_properties (
  input wire logic       mclk_i,              // Clock
  input wire logic       rst_i,               // Reset
  input wire logic       ce_i,                // Enable
  input wire logic       avs_read_i,          // Read
  input wire logic       avs_write_i,         // Write
  input wire logic       avs_waitrequest_o,   // Wait
  input wire logic       ch0_count_end_irq_i, // Event 0
  input wire logic       ch1_count_end_irq_i, // Event 1
  input wire logic [1:0] ch_start_o,          // Starts
  input wire logic [1:0] ch_enable_status_o,  // Status
  input wire logic       ch0_pin_o,           // Pin 0
  input wire logic       ch0_pin_oe_o,        // Pin 0 drive
  input wire logic       irq_o                // Interrupt
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================================
  // Age since last event, so an irq rise must have a recent cause
  logic [3:0] ev_age_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i || ch0_count_end_irq_i || ch1_count_end_irq_i) ev_age_r <= 4'h0;
    else if (ev_age_r != 4'hF) ev_age_r <= ev_age_r + 4'h1;
  end
  // ==========================================================================
  // Assertions
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o)
    else $error("request not answered");
  ack_single_a: assert property (ce_i && !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("ack longer than one cycle");
  reset_state_a: assert property ($fell(rst_i) |-> avs_waitrequest_o && !irq_o && !ch0_pin_oe_o && ch_enable_status_o == 2'h0)
    else $error("bad state after reset");
  start_status_a: assert property (ch_start_o != 2'h0 |=> (ch_enable_status_o & $past(ch_start_o)) == $past(ch_start_o))
    else $error("start did not set status");
  status_hold_a: assert property (ch_enable_status_o != 2'h0 |=> (ch_enable_status_o & $past(ch_enable_status_o)) == $past(ch_enable_status_o))
    else $error("status bit lost");
  irq_rise_a: assert property ($rose(irq_o) |-> ev_age_r <= 4'h8 || $past(avs_write_i))
    else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("irq fell without access");
  oe_change_a: assert property ($changed(ch0_pin_oe_o) |-> $past(avs_write_i))
    else $error("pin drive changed without write");
  // Main scenarios
  cover property ($rose(irq_o));
  cover property (ch_start_o == 2'h2);
  cover property ($changed(ch0_pin_o) && ch0_pin_oe_o);
endmodule : tosc_properties

bind tosc_top tosc_properties u_tosc_properties (.*);

// ===== tb/tosc_timer_model.sv
// Behavioural master and slave timer channels feeding count-end events
`timescale 1ns/1ps
module tosc_timer_model #(
  parameter int unsigned PERIOD  = 15, // Master period value
  parameter int unsigned COMPARE = 5   // Slave compare value
) (
  input  wire logic       mclk_i,    // Clock
  input  wire logic       rst_i,     // Reset
  input  wire logic       hold_i,    // Freeze counting
  input  wire logic [1:0] start_i,   // Start pulses
  output logic            ch0_evt_o, // Master count end
  output logic            ch1_evt_o  // Slave match
);
  logic [1:0] run_r;
  logic [7:0] cnt_r;
  // Counting begins once the start pulse has arrived
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      run_r <= 2'h0;
      cnt_r <= 8'h00;
    end else begin
      run_r <= run_r | start_i;
      if (run_r[0] && !hold_i) cnt_r <= (cnt_r == 8'(PERIOD)) ? 8'h00 : cnt_r + 8'h01;
    end
  end
  // Two-cycle events so the block's synchroniser cannot miss them
  assign ch0_evt_o = run_r[0] && !hold_i && cnt_r < 8'h02;
  assign ch1_evt_o = run_r[1] && !hold_i && cnt_r >= 8'(COMPARE) && cnt_r < 8'(COMPARE + 2);
endmodule : tosc_timer_model

// ===== tb/tosc_top_tb.sv
// Self-checking bench for the timer output and start control block
`timescale 1ns/1ps
module tosc_top_tb;
  import tosc_pkg::*;
  localparam int CMP = 5;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic        hold = 1'b1;
  logic [5:0]  addr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd_q;
  logic        wait_q, waitreq, pin0, oe0, pin1, oe1, irq, ev0, ev1;
  logic [1:0]  start, status;
  int          failures = 0;
  int          tests_run = 0;
  always #2 mclk = ~mclk;
  tosc_top u_tosc_top (.mclk_i(mclk), .rst_i(rst), .ce_i(1'b1), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(waitreq), .ch0_count_end_irq_i(ev0), .ch1_count_end_irq_i(ev1), .ch_start_o(start),
    .ch_enable_status_o(status), .ch0_pin_o(pin0), .ch0_pin_oe_o(oe0), .ch1_pin_o(pin1), .ch1_pin_oe_o(oe1),
    .irq_o(irq));
  tosc_timer_model #(.PERIOD(15), .COMPARE(CMP)) u_tosc_timer_model (.mclk_i(mclk), .rst_i(rst),
    .hold_i(hold), .start_i(start), .ch0_evt_o(ev0), .ch1_evt_o(ev1));
  // Settled bus answer, taken before each rising edge to avoid racing the design
  always @(negedge mclk) begin
    wait_q = waitreq;
    rd_q = rdat;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus cycle, held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_q !== 1'b0 && n < 40);
    if (n >= 40) chk("bus wait", 0, 1);
    q = rd_q;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc
  task automatic w8(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask : w8
  task automatic r8(input string nm, input logic [5:0] a, input logic [7:0] e);
    logic [31:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask : r8
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Hang guard: the tests need well under 2000 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    chk("watchdog", 0, 1);
    summarize();
  end
  initial begin
    logic [5:0]  ra [7] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h1C, 6'h2C};
    logic [7:0]  re [7] = '{TOSC_PORT0_RST, TOSC_DIR_RST, TOSC_FLAG_RST, TOSC_MASK_RST, 8'h00, 8'h00, 8'h00};
    logic [31:0] r, q;
    int          hi, tg;
    logic        p;
    void'($urandom(32'h9AAEAB43));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    foreach (ra[i]) r8("reset value", ra[i], re[i]);
    $display("test reset done");
    // Random direction, level and latch values; output enable still clear
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      w8(6'h04, r[7:0]);
      w8(6'h18, {7'h0, r[8]});
      w8(6'h00, r[23:16]);
      @(negedge mclk);
      chk("pin0 drive", {31'h0, !r[4]}, {31'h0, oe0});
      chk("pin0 level", {31'h0, r[8]}, {31'h0, pin0});
      r8("latch", 6'h00, r[23:16]);
    end
    $display("test pins done");
    w8(6'h08, 8'h00);
    w8(6'h04, 8'h00);
    w8(6'h20, 8'h01);
    w8(6'h14, 8'h03);
    hold <= 1'b0;
    w8(6'h10, 8'h00);
    repeat (3) @(negedge mclk);
    chk("no start", 0, {30'h0, status});
    w8(6'h10, 8'h01);
    repeat (3) @(negedge mclk);
    chk("start ch0", 1, {30'h0, status});
    w8(6'h10, 8'h02);
    r8("status", 6'h1C, 8'h03);
    $display("test start done");
    repeat (40) @(negedge mclk);
    hi = 0;
    tg = 0;
    p = pin0;
    for (int i = 0; i < 64; i++) begin
      @(negedge mclk);
      tg += int'(pin0 !== p);
      p = pin0;
      hi += int'(i < 16 && pin1 === 1'b1);
    end
    chk("pin0 toggles", 4, tg);
    chk("pin1 high", CMP, hi);
    chk("pin1 drive", 1, {31'h0, oe1});
    $display("test waveform done");
    @(posedge mclk);
    hold <= 1'b1;
    repeat (8) @(negedge mclk);
    chk("irq masked", 0, {31'h0, irq});
    acc(1'b0, 6'h08, 8'h00, q);
    chk("flag set", 1, {31'h0, q[7]});
    r8("flag clear", 6'h08, 8'h00);
    p = pin0;
    w8(6'h18, {7'h0, !p});
    repeat (2) @(negedge mclk);
    chk("pin0 kept", {31'h0, p}, {31'h0, pin0});
    w8(6'h0C, 8'h7F);
    hold <= 1'b0;
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge mclk);
    chk("irq raised", 1, {31'h0, irq});
    @(posedge mclk);
    hold <= 1'b1;
    repeat (8) @(negedge mclk);
    acc(1'b0, 6'h08, 8'h00, q);
    repeat (2) @(negedge mclk);
    chk("irq cleared", 0, {31'h0, irq});
    $display("test interrupt done");
    summarize();
  end
endmodule : tosc_top_tb
